// *** src/port_cfg_pkg.sv ***
package port_cfg_pkg;
    // Register offsets on the plain register port (8-bit address)
    localparam logic [7:0] ADDR_P1_LOW = 8'h00;
    localparam logic [7:0] ADDR_P1_HIGH = 8'h01;
    localparam logic [7:0] ADDR_P2_LOW = 8'h02;
    localparam logic [7:0] ADDR_P2_HIGH = 8'h03;
    localparam logic [7:0] ADDR_P3_LOW = 8'h04;
    localparam logic [7:0] ADDR_P3_HIGH = 8'h05;
    localparam logic [7:0] ADDR_MOD0_CTRL = 8'h06;
    localparam logic [7:0] ADDR_P1_LATCH = 8'h07;
    localparam logic [7:0] ADDR_P2_LATCH = 8'h08;
    localparam logic [7:0] ADDR_P3_LATCH = 8'h09;
    localparam logic [7:0] ADDR_P1_PINS = 8'h0A;
    localparam logic [7:0] ADDR_P2_PINS = 8'h0B;
    localparam logic [7:0] ADDR_P3_PINS = 8'h0C;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Modulator control field layout
    localparam int MOD0_EN_BIT = 7;
    localparam int MOD0_PIN = 0;

    // Pin drive modes, high bit from the high register
    typedef enum logic [1:0] {
        MODE_OPEN_DRAIN = 2'h0,
        MODE_QUASI = 2'h1,
        MODE_HIGH_Z = 2'h2,
        MODE_PUSH_PULL = 2'h3
    } pin_mode_e;
endpackage

// *** src/port_pin_mode_config.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Port 2 pin mode from same-position bits
// - Port 3 pin mode from its register pair
// - Code 00 is open-drain, low only
// - Code 01 is quasi-bidirectional
// - Code 10 is high-impedance, driver off
// - Code 11 is push-pull from latch
// - Port 3 uses the same encoding
// - Port 1 uses the same encoding
// - Modulator 0 enable takes over pin
module port_pin_mode_config (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Modulator 0 waveform
    input wire logic mod0_wave,
    // Port 1 pins
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    // Port 2 pins
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    // Port 3 pins
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Drive decision for one pin: {oe_n, out}
    function automatic logic [1:0] pin_drive(input logic hi, input logic lo,
                                             input logic val);
        port_cfg_pkg::pin_mode_e mode;
        mode = port_cfg_pkg::pin_mode_e'({hi, lo});
        unique case (mode)
            port_cfg_pkg::MODE_OPEN_DRAIN: pin_drive = {val, 1'b0};
            // Weak pull-up is external; only low is driven strongly
            port_cfg_pkg::MODE_QUASI: pin_drive = {val, 1'b0};
            port_cfg_pkg::MODE_HIGH_Z: pin_drive = {1'b1, 1'b0};
            port_cfg_pkg::MODE_PUSH_PULL: pin_drive = {1'b0, val};
        endcase
    endfunction

    // Byte-wide views: every port goes through the same two calls, so
    // the encoding cannot drift from one port to the next
    function automatic logic [7:0] port_oe_n(input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic [7:0] val);
        logic [1:0] one;
        port_oe_n = port_cfg_pkg::ZERO_BYTE;
        for (int i = 0; i < 8; i++) begin
            one = pin_drive(hi[i], lo[i], val[i]);
            port_oe_n[i] = one[1];
        end
    endfunction

    function automatic logic [7:0] port_out(input logic [7:0] hi,
                                            input logic [7:0] lo,
                                            input logic [7:0] val);
        logic [1:0] one;
        port_out = port_cfg_pkg::ZERO_BYTE;
        for (int i = 0; i < 8; i++) begin
            one = pin_drive(hi[i], lo[i], val[i]);
            port_out[i] = one[0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] p1_low, p1_high, p2_low, p2_high, p3_low, p3_high;
    logic [7:0] p1_latch, p2_latch, p3_latch;
    logic mod0_enable;
    logic [7:0] p1_sync1, p1_sync2, p2_sync1, p2_sync2, p3_sync1, p3_sync2;
    logic mod0_sync1, mod0_sync2;

    ////////////////////////////////////////////////////////////////////////
    // Pin model: each pin is a pad with an output value and an active-low
    // enable. Open-drain and quasi modes only ever drive a low; a high is
    // left to the external pull-up, so a slow rising edge is the price of
    // never fighting another driver on a shared line. Quasi mode has no
    // strong high pulse here, a limitation software must allow for.
    // High-impedance keeps the driver off whatever the latch holds, and
    // push-pull drives both levels straight from the latch.
    // Pin levels come back through two flops, so a read of a pin register
    // shows what the pad saw two to three cycles earlier.

    // Address hits for the read select
    wire hit_p1_low = reg_addr == port_cfg_pkg::ADDR_P1_LOW;
    wire hit_p1_high = reg_addr == port_cfg_pkg::ADDR_P1_HIGH;
    wire hit_p2_low = reg_addr == port_cfg_pkg::ADDR_P2_LOW;
    wire hit_p2_high = reg_addr == port_cfg_pkg::ADDR_P2_HIGH;
    wire hit_p3_low = reg_addr == port_cfg_pkg::ADDR_P3_LOW;
    wire hit_p3_high = reg_addr == port_cfg_pkg::ADDR_P3_HIGH;
    wire hit_mod0 = reg_addr == port_cfg_pkg::ADDR_MOD0_CTRL;
    wire hit_p1_latch = reg_addr == port_cfg_pkg::ADDR_P1_LATCH;
    wire hit_p2_latch = reg_addr == port_cfg_pkg::ADDR_P2_LATCH;
    wire hit_p3_latch = reg_addr == port_cfg_pkg::ADDR_P3_LATCH;
    wire hit_p1_pins = reg_addr == port_cfg_pkg::ADDR_P1_PINS;
    wire hit_p2_pins = reg_addr == port_cfg_pkg::ADDR_P2_PINS;
    wire hit_p3_pins = reg_addr == port_cfg_pkg::ADDR_P3_PINS;

    // Write decode
    wire wr_p1_low = reg_wr && reg_addr == port_cfg_pkg::ADDR_P1_LOW;
    wire wr_p1_high = reg_wr && reg_addr == port_cfg_pkg::ADDR_P1_HIGH;
    wire wr_p2_low = reg_wr && reg_addr == port_cfg_pkg::ADDR_P2_LOW;
    wire wr_p2_high = reg_wr && reg_addr == port_cfg_pkg::ADDR_P2_HIGH;
    wire wr_p3_low = reg_wr && reg_addr == port_cfg_pkg::ADDR_P3_LOW;
    wire wr_p3_high = reg_wr && reg_addr == port_cfg_pkg::ADDR_P3_HIGH;
    wire wr_mod0 = reg_wr && reg_addr == port_cfg_pkg::ADDR_MOD0_CTRL;
    wire wr_p1_latch = reg_wr && reg_addr == port_cfg_pkg::ADDR_P1_LATCH;
    wire wr_p2_latch = reg_wr && reg_addr == port_cfg_pkg::ADDR_P2_LATCH;
    wire wr_p3_latch = reg_wr && reg_addr == port_cfg_pkg::ADDR_P3_LATCH;

    // Port 1 mode registers; reset leaves every pin open-drain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_low <= port_cfg_pkg::MODE_RESET;
            p1_high <= port_cfg_pkg::MODE_RESET;
        end else begin
            if (wr_p1_low) p1_low <= reg_wdata;
            if (wr_p1_high) p1_high <= reg_wdata;
        end
    end

    // Port 2 mode registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2_low <= port_cfg_pkg::MODE_RESET;
            p2_high <= port_cfg_pkg::MODE_RESET;
        end else begin
            if (wr_p2_low) p2_low <= reg_wdata;
            if (wr_p2_high) p2_high <= reg_wdata;
        end
    end

    // Port 3 mode registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_low <= port_cfg_pkg::MODE_RESET;
            p3_high <= port_cfg_pkg::MODE_RESET;
        end else begin
            if (wr_p3_low) p3_low <= reg_wdata;
            if (wr_p3_high) p3_high <= reg_wdata;
        end
    end

    // Output latches; reset high so open-drain pins start released
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_latch <= port_cfg_pkg::LATCH_RESET;
            p2_latch <= port_cfg_pkg::LATCH_RESET;
            p3_latch <= port_cfg_pkg::LATCH_RESET;
        end else begin
            if (wr_p1_latch) p1_latch <= reg_wdata;
            if (wr_p2_latch) p2_latch <= reg_wdata;
            if (wr_p3_latch) p3_latch <= reg_wdata;
        end
    end

    // Modulator enable; off after reset so the latch owns the pin until
    // software hands it over
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod0_enable <= 1'b0;
        end else begin
            if (wr_mod0) mod0_enable <= reg_wdata[port_cfg_pkg::MOD0_EN_BIT];
        end
    end

    // Pin and waveform synchronisers; first stage feeds only the second.
    // Reset clears both stages so no stale level leaks out after reset.
    // Port 1 pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_sync1 <= port_cfg_pkg::ZERO_BYTE;
            p1_sync2 <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p1_sync1 <= p1_in;
            p1_sync2 <= p1_sync1;
        end
    end

    // Port 2 pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2_sync1 <= port_cfg_pkg::ZERO_BYTE;
            p2_sync2 <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p2_sync1 <= p2_in;
            p2_sync2 <= p2_sync1;
        end
    end

    // Port 3 pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_sync1 <= port_cfg_pkg::ZERO_BYTE;
            p3_sync2 <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p3_sync1 <= p3_in;
            p3_sync2 <= p3_sync1;
        end
    end

    // Modulator waveform synchroniser; it comes from another clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod0_sync1 <= 1'b0;
            mod0_sync2 <= 1'b0;
        end else begin
            mod0_sync1 <= mod0_wave;
            mod0_sync2 <= mod0_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: data stand one cycle after the strobe, zero otherwise.
    // An and-or select gives zero for unmapped addresses with no default
    // arm, and keeps the mux flat for timing.
    wire [7:0] mod0_byte = 8'(mod0_enable) << port_cfg_pkg::MOD0_EN_BIT;
    wire [7:0] read_mux =
        ({8{hit_p1_low}} & p1_low) |
        ({8{hit_p1_high}} & p1_high) |
        ({8{hit_p2_low}} & p2_low) |
        ({8{hit_p2_high}} & p2_high) |
        ({8{hit_p3_low}} & p3_low) |
        ({8{hit_p3_high}} & p3_high) |
        ({8{hit_mod0}} & mod0_byte) |
        ({8{hit_p1_latch}} & p1_latch) |
        ({8{hit_p2_latch}} & p2_latch) |
        ({8{hit_p3_latch}} & p3_latch) |
        ({8{hit_p1_pins}} & p1_sync2) |
        ({8{hit_p2_pins}} & p2_sync2) |
        ({8{hit_p3_pins}} & p3_sync2);

    always_ff @(posedge clk) begin
        if (!rst_n) reg_rdata <= port_cfg_pkg::ZERO_BYTE;
        else if (reg_rd) reg_rdata <= read_mux;
        else reg_rdata <= port_cfg_pkg::ZERO_BYTE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Port 1 value with modulator 0 takeover of its pin
    logic [7:0] p1_value;
    always_comb begin
        p1_value = p1_latch;
        if (mod0_enable) p1_value[port_cfg_pkg::MOD0_PIN] = mod0_sync2;
    end

    // Next pad state per port; registering it costs a cycle of latency
    // but keeps glitches from the decode off the pins
    wire [7:0] next_p1_oe_n = port_oe_n(p1_high, p1_low, p1_value);
    wire [7:0] next_p1_out = port_out(p1_high, p1_low, p1_value);
    wire [7:0] next_p2_oe_n = port_oe_n(p2_high, p2_low, p2_latch);
    wire [7:0] next_p2_out = port_out(p2_high, p2_low, p2_latch);
    wire [7:0] next_p3_oe_n = port_oe_n(p3_high, p3_low, p3_latch);
    wire [7:0] next_p3_out = port_out(p3_high, p3_low, p3_latch);

    // Port 1 pads; drivers off while in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_oe_n <= port_cfg_pkg::LATCH_RESET;
            p1_out <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p1_oe_n <= next_p1_oe_n;
            p1_out <= next_p1_out;
        end
    end

    // Port 2 pads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2_oe_n <= port_cfg_pkg::LATCH_RESET;
            p2_out <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p2_oe_n <= next_p2_oe_n;
            p2_out <= next_p2_out;
        end
    end

    // Port 3 pads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_oe_n <= port_cfg_pkg::LATCH_RESET;
            p3_out <= port_cfg_pkg::ZERO_BYTE;
        end else begin
            p3_oe_n <= next_p3_oe_n;
            p3_out <= next_p3_out;
        end
    end

endmodule

`default_nettype wire

// *** verif/port_pin_mode_config_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_pin_mode_config_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic mod0_wave = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] pin_in [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] pin_out [3];
    logic [7:0] pin_oe_n [3];
    int mismatches = 0;
    int samples_checked = 0;
    // 200 MHz core clock
    always #2.5 clk = ~clk;
    port_pin_mode_config i_dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod0_wave(mod0_wave),
        .p1_in(pin_in[0]), .p1_out(pin_out[0]), .p1_oe_n(pin_oe_n[0]),
        .p2_in(pin_in[1]), .p2_out(pin_out[1]), .p2_oe_n(pin_oe_n[1]),
        .p3_in(pin_in[2]), .p3_out(pin_out[2]), .p3_oe_n(pin_oe_n[2]));
    ////////////////////////////////////////////////////////////////////////
    // The wr and rd tasks leave strobes up so back-to-back cycles need no gap
    task automatic check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        #1 check("read data", reg_rdata, exp);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs well under a microsecond
    initial begin
        #20000;
        mismatches++;
        $display("ERROR watchdog expected done seen timeout");
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd(8'(a), 8'h00);
        $display("reset test done");
        // Codes 00 01 10 11 twice per port, latch 96 covers both levels
        for (int p = 0; p < 3; p++) begin
            wr(8'(2 * p), 8'hAA);
            wr(8'(2 * p + 1), 8'hCC);
            wr(8'(7 + p), 8'h96);
            pin_in[p] <= 8'h3C;
            idle(3);
            rd(8'(2 * p + 1), 8'hCC);
            rd(8'(10 + p), 8'h3C);
            check("oe_n", pin_oe_n[p], 8'h56);
            check("out", pin_out[p], 8'h80);
        end
        $display("encoding test done");
        wr(port_cfg_pkg::ADDR_P2_LOW, 8'hFF);
        wr(port_cfg_pkg::ADDR_P2_HIGH, 8'hFF);
        rd(port_cfg_pkg::ADDR_P2_HIGH, 8'hFF);
        check("p2 oe_n", pin_oe_n[1], 8'h00);
        check("p2 out", pin_out[1], 8'h96);
        wr(port_cfg_pkg::ADDR_P3_HIGH, 8'hFF);
        wr(port_cfg_pkg::ADDR_P3_LOW, 8'h00);
        rd(port_cfg_pkg::ADDR_P3_LOW, 8'h00);
        check("p3 oe_n", pin_oe_n[2], 8'hFF);
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h00);
        $display("back to back test done");
        // Modulator takes pin 0 of port 1 only when enabled
        wr(port_cfg_pkg::ADDR_P1_LOW, 8'hFF);
        wr(port_cfg_pkg::ADDR_P1_HIGH, 8'hFF);
        wr(port_cfg_pkg::ADDR_P1_LATCH, 8'h00);
        mod0_wave <= 1'b1;
        idle(4);
        check("latch pin", {7'h00, pin_out[0][0]}, 8'h00);
        wr(port_cfg_pkg::ADDR_MOD0_CTRL, 8'h80);
        idle(4);
        check("wave high", {7'h00, pin_out[0][0]}, 8'h01);
        mod0_wave <= 1'b0;
        idle(4);
        check("wave low", {7'h00, pin_out[0][0]}, 8'h00);
        $display("modulator test done");
        tally_and_finish();
    end
endmodule
bind port_pin_mode_config port_pin_mode_config_properties u_props (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p3_out(p3_out), .p3_oe_n(p3_oe_n));
`default_nettype wire

// *** verif/port_pin_mode_config_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_pin_mode_config_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Port 2 and port 3 pins
    input wire logic [7:0] p2_out,
    input wire logic [7:0] p2_oe_n,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Read data only stands in the cycle after a read
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h0C
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_P2_BACK: assert property (reg_wr && reg_addr == 8'h03 ##1
        reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("port 2 high readback wrong");
    AST_P3_BACK: assert property (reg_wr && reg_addr == 8'h04 ##1
        reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("port 3 low readback wrong");
    // A pin may only show high while it is driven
    AST_P2_NO_FLOAT_HIGH: assert property ((p2_out & p2_oe_n) == 8'h00)
        else $error("port 2 high while not driven");
    AST_P3_NO_FLOAT_HIGH: assert property ((p3_out & p3_oe_n) == 8'h00)
        else $error("port 3 high while not driven");
    AST_P2_PUSH_PULL: assert property (reg_wr && reg_addr == 8'h02 &&
        reg_wdata == 8'hFF ##1 reg_wr && reg_addr == 8'h03 &&
        reg_wdata == 8'hFF |=> ##1 p2_oe_n == 8'h00)
        else $error("port 2 not driving in push-pull");
    AST_P3_HIGH_Z: assert property (reg_wr && reg_addr == 8'h05 &&
        reg_wdata == 8'hFF ##1 reg_wr && reg_addr == 8'h04 &&
        reg_wdata == 8'h00 |=> ##1 p3_oe_n == 8'hFF && p3_out == 8'h00)
        else $error("port 3 driving in high impedance");
    // Main scenarios
    cover property (reg_wr ##1 reg_rd);
    cover property (p2_oe_n == 8'h00);
    cover property (p3_oe_n == 8'hFF);
endmodule
`default_nettype wire
